// ===== cirp_i2c_port.sv
module cirp_i2c_port
   import cirp_pkg::*;
#(
   parameter int WD_TICK_CYCLES = CIRP_TICK_CYCLES,
   parameter int WD_LIMIT_TICKS = CIRP_WD_LIMIT_TICKS
)
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   input wire logic hostMode,
   input wire logic [7:0] chargeStatus,
   input wire logic [7:0] faultStatus,
   output cirp_cfg_t cfg,
   output logic busBusy
);

   localparam logic [CIRP_PRE_W-1:0] PRE_LAST = CIRP_PRE_W'(WD_TICK_CYCLES - 1);
   localparam logic [CIRP_MS_W-1:0] TICKS_LAST = CIRP_MS_W'(WD_LIMIT_TICKS - 1);

   cirp_regs_t r_reg;
   cirp_regs_t r_next;

   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;
   logic wdEnabled;
   logic wdExpire;

   // Register read decode; status registers come straight from the core
   function automatic logic [7:0] regRead(input logic [2:0] ptr, input cirp_cfg_t c,
                                          input logic [7:0] chg, input logic [7:0] flt);
      logic [7:0] v;
      v = 8'h00;
      unique case (ptr)
         CIRP_CHARGE_VOLTAGE_CONFIG: v = c.chargeVoltageConfig;
         CIRP_BALANCE_CURRENT_CONFIG: v = c.balanceCurrentConfig;
         CIRP_TIMER_CONFIG: v = c.timerConfig;
         CIRP_CHARGE_STATUS: v = chg;
         CIRP_FAULT_STATUS: v = flt;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : regRead

   // Reset pattern of the setting registers
   function automatic cirp_cfg_t cfgDefault();
      cirp_cfg_t c;
      c.chargeVoltageConfig = CIRP_CHARGE_VOLTAGE_RST;
      c.balanceCurrentConfig = CIRP_BALANCE_CURRENT_RST;
      c.timerConfig = CIRP_TIMER_RST;
      return c;
   endfunction : cfgDefault

   // Edges on the synchronised lines; the first stage is never looked at
   assign sclRise = r_reg.sclS2 & ~r_reg.sclPrev;
   assign sclFall = ~r_reg.sclS2 & r_reg.sclPrev;
   assign startSeen = r_reg.sclS2 & r_reg.sclPrev & r_reg.sdaPrev & ~r_reg.sdaS2;
   assign stopSeen = r_reg.sclS2 & r_reg.sclPrev & ~r_reg.sdaPrev & r_reg.sdaS2;
   assign wdEnabled = hostMode &
      (r_reg.cfg.timerConfig[CIRP_WD_SEL_HI:CIRP_WD_SEL_LO] != 2'b00);
   assign wdExpire = wdEnabled && r_reg.wdPre == PRE_LAST && r_reg.wdTicks == TICKS_LAST;

   // Next-state logic of the whole port
   always_comb
   begin
      r_next = r_reg;
      // Oversampling at 200 MHz keeps many samples per bit even at 400 kbit/s
      r_next.sclS1 = sclIn;
      r_next.sclS2 = r_reg.sclS1;
      r_next.sclPrev = r_reg.sclS2;
      r_next.sdaS1 = sdaIn;
      r_next.sdaS2 = r_reg.sdaS1;
      r_next.sdaPrev = r_reg.sdaS2;

      // Sample on the rising edge, while the controller holds SDA steady
      if (sclRise)
      begin
         r_next.rxShift = {r_reg.rxShift[6:0], r_reg.sdaS2};
         if (r_reg.bitCnt != CIRP_BYTE_BITS)
         begin
            r_next.bitCnt = r_reg.bitCnt + 4'h1;
         end
      end

      // All driving changes happen on the falling edge, so SDA moves only while SCL is low
      if (sclFall)
      begin
         unique case (r_reg.fsm)
            CIRP_IDLE, CIRP_IGNORE:
            begin
               r_next.sdaOeN = 1'b1;
            end
            CIRP_ADDR:
            begin
               if (r_reg.bitCnt == CIRP_BYTE_BITS)
               begin
                  r_next.bitCnt = 4'h0;
                  if (r_reg.rxShift[7:1] == CIRP_TARGET_ADDR)
                  begin
                     r_next.readDir = r_reg.rxShift[0];
                     r_next.sdaOeN = 1'b0;
                     r_next.fsm = CIRP_ADDR_ACK;
                  end
                  else
                  begin
                     r_next.fsm = CIRP_IGNORE;
                  end
               end
            end
            CIRP_ADDR_ACK:
            begin
               r_next.bitCnt = 4'h0;
               if (r_reg.readDir)
               begin
                  // First data bit goes out right after the acknowledge clock
                  r_next.txShift = regRead(r_reg.regPtr, r_reg.cfg, chargeStatus, faultStatus);
                  // MSB of the loaded byte decides whether the line is pulled low
                  r_next.sdaOeN = r_next.txShift[7];
                  r_next.fsm = CIRP_RDATA;
               end
               else
               begin
                  r_next.sdaOeN = 1'b1;
                  r_next.fsm = CIRP_REG;
               end
            end
            CIRP_REG:
            begin
               if (r_reg.bitCnt == CIRP_BYTE_BITS)
               begin
                  r_next.bitCnt = 4'h0;
                  if (r_reg.rxShift < 8'(CIRP_NUM_REGS))
                  begin
                     r_next.regPtr = r_reg.rxShift[2:0];
                     r_next.sdaOeN = 1'b0;
                     r_next.fsm = CIRP_REG_ACK;
                  end
                  else
                  begin
                     r_next.fsm = CIRP_IDLE;
                  end
               end
            end
            CIRP_REG_ACK:
            begin
               r_next.bitCnt = 4'h0;
               r_next.sdaOeN = 1'b1;
               r_next.fsm = CIRP_WDATA;
            end
            CIRP_WDATA:
            begin
               if (r_reg.bitCnt == CIRP_BYTE_BITS)
               begin
                  r_next.bitCnt = 4'h0;
                  r_next.txShift = r_reg.rxShift; // Byte held until its acknowledge ends
                  r_next.sdaOeN = 1'b0;
                  r_next.fsm = CIRP_WDATA_ACK;
               end
            end
            CIRP_WDATA_ACK:
            begin
               r_next.sdaOeN = 1'b1;
               r_next.fsm = CIRP_IGNORE;
               // Commit only now that the acknowledge has been given
               unique case (r_reg.regPtr)
                  CIRP_CHARGE_VOLTAGE_CONFIG:
                     r_next.cfg.chargeVoltageConfig = r_reg.txShift;
                  CIRP_BALANCE_CURRENT_CONFIG:
                     r_next.cfg.balanceCurrentConfig = r_reg.txShift;
                  CIRP_TIMER_CONFIG:
                  begin
                     // Kick bit acts once and reads back as zero
                     r_next.cfg.timerConfig = r_reg.txShift;
                     r_next.cfg.timerConfig[CIRP_WD_KICK_BIT] = 1'b0;
                  end
                  default:
                  begin
                     r_next.cfg = r_reg.cfg;
                  end
               endcase
            end
            CIRP_RDATA:
            begin
               if (r_reg.bitCnt == CIRP_BYTE_BITS)
               begin
                  r_next.bitCnt = 4'h0;
                  r_next.sdaOeN = 1'b1;
                  r_next.fsm = CIRP_RACK;
               end
               else
               begin
                  r_next.txShift = {r_reg.txShift[6:0], 1'b0};
                  r_next.sdaOeN = r_reg.txShift[6];
               end
            end
            CIRP_RACK:
            begin
               // Single byte only: an ACK from the controller still ends the read
               r_next.sdaOeN = 1'b1;
               r_next.fsm = CIRP_IGNORE;
            end
            default:
            begin
               r_next.sdaOeN = 1'b1;
               r_next.fsm = CIRP_IDLE;
            end
         endcase
      end

      // Start or repeated start wins over any byte in progress
      if (startSeen)
      begin
         r_next.busy = 1'b1;
         r_next.fsm = CIRP_ADDR;
         r_next.bitCnt = 4'h0;
         r_next.sdaOeN = 1'b1;
      end
      else if (stopSeen)
      begin
         r_next.busy = 1'b0;
         r_next.fsm = CIRP_IDLE;
         r_next.bitCnt = 4'h0;
         r_next.sdaOeN = 1'b1;
      end

      // Watchdog: serviced by any addressed transfer or by the kick bit
      if (!wdEnabled || r_reg.fsm == CIRP_ADDR_ACK ||
          (r_reg.fsm == CIRP_WDATA_ACK && sclFall && r_reg.regPtr == CIRP_TIMER_CONFIG &&
           r_reg.txShift[CIRP_WD_KICK_BIT]))
      begin
         r_next.wdPre = '0;
         r_next.wdTicks = '0;
      end
      else if (wdExpire)
      begin
         r_next.wdPre = '0;
         r_next.wdTicks = '0;
         r_next.cfg = cfgDefault();
      end
      else if (r_reg.wdPre == PRE_LAST)
      begin
         r_next.wdPre = '0;
         r_next.wdTicks = r_reg.wdTicks + CIRP_MS_W'(1);
      end
      else
      begin
         r_next.wdPre = r_reg.wdPre + CIRP_PRE_W'(1);
      end
   end

   // State register; lines reset to their released, idle-high level
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         r_reg.sclS1 <= 1'b1;
         r_reg.sclS2 <= 1'b1;
         r_reg.sclPrev <= 1'b1;
         r_reg.sdaS1 <= 1'b1;
         r_reg.sdaS2 <= 1'b1;
         r_reg.sdaPrev <= 1'b1;
         r_reg.fsm <= CIRP_IDLE;
         r_reg.bitCnt <= 4'h0;
         r_reg.rxShift <= 8'h00;
         r_reg.txShift <= 8'h00;
         r_reg.readDir <= 1'b0;
         r_reg.regPtr <= 3'h0;
         r_reg.sdaOeN <= 1'b1;
         r_reg.busy <= 1'b0;
         r_reg.cfg.chargeVoltageConfig <= CIRP_CHARGE_VOLTAGE_RST;
         r_reg.cfg.balanceCurrentConfig <= CIRP_BALANCE_CURRENT_RST;
         r_reg.cfg.timerConfig <= CIRP_TIMER_RST;
         r_reg.wdPre <= '0;
         r_reg.wdTicks <= '0;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // Open drain: only ever pull low, never drive high
   assign sdaOut = 1'b0;
   assign sdaOeN = r_reg.sdaOeN;
   assign cfg = r_reg.cfg;
   assign busBusy = r_reg.busy;

endmodule : cirp_i2c_port

// ===== cirp_pkg.sv
package cirp_pkg;

   localparam logic [6:0] CIRP_TARGET_ADDR = 7'h4B;
   localparam int CIRP_NUM_REGS = 5;
   localparam int CIRP_NUM_CFG = 3;
   localparam logic [2:0] CIRP_CHARGE_VOLTAGE_CONFIG = 3'h0;
   localparam logic [2:0] CIRP_BALANCE_CURRENT_CONFIG = 3'h1;
   localparam logic [2:0] CIRP_TIMER_CONFIG = 3'h2;
   localparam logic [2:0] CIRP_CHARGE_STATUS = 3'h3;
   localparam logic [2:0] CIRP_FAULT_STATUS = 3'h4;
   localparam logic [7:0] CIRP_CHARGE_VOLTAGE_RST = 8'h38;
   localparam logic [7:0] CIRP_BALANCE_CURRENT_RST = 8'h8F;
   localparam logic [7:0] CIRP_TIMER_RST = 8'h95;
   // Timer register fields: watchdog kick bit and watchdog enable field
   localparam int CIRP_WD_KICK_BIT = 6;
   localparam int CIRP_WD_SEL_HI = 5;
   localparam int CIRP_WD_SEL_LO = 4;
   // Bit counter value once a whole byte has been clocked
   localparam logic [3:0] CIRP_BYTE_BITS = 4'h8;
   // Watchdog timing: a 1 ms tick and a 40 s limit
   localparam int CIRP_CLK_HZ = 200000000;
   localparam int CIRP_TICK_MS = 1;
   localparam int CIRP_TICK_CYCLES = CIRP_CLK_HZ / 1000 * CIRP_TICK_MS;
   localparam int CIRP_WD_TIME_S = 40;
   localparam int CIRP_WD_LIMIT_TICKS = CIRP_WD_TIME_S * 1000 / CIRP_TICK_MS;
   localparam int CIRP_PRE_W = 18;
   localparam int CIRP_MS_W = 16;

   typedef enum logic [3:0] {
      CIRP_IDLE,
      CIRP_ADDR,
      CIRP_ADDR_ACK,
      CIRP_REG,
      CIRP_REG_ACK,
      CIRP_WDATA,
      CIRP_WDATA_ACK,
      CIRP_RDATA,
      CIRP_RACK,
      CIRP_IGNORE
   } cirp_state_t;

   // Setting registers as seen by the charger core
   typedef struct packed {
      logic [7:0] chargeVoltageConfig;
      logic [7:0] balanceCurrentConfig;
      logic [7:0] timerConfig;
   } cirp_cfg_t;

   // Whole state of the port
   typedef struct packed {
      logic sclS1;
      logic sclS2;
      logic sclPrev;
      logic sdaS1;
      logic sdaS2;
      logic sdaPrev;
      cirp_state_t fsm;
      logic [3:0] bitCnt;
      logic [7:0] rxShift;
      logic [7:0] txShift;
      logic readDir;
      logic [2:0] regPtr;
      logic sdaOeN;
      logic busy;
      cirp_cfg_t cfg;
      logic [CIRP_PRE_W-1:0] wdPre;
      logic [CIRP_MS_W-1:0] wdTicks;
   } cirp_regs_t;

endpackage : cirp_pkg

// ===== cirp_i2c_port_asserts.sv
module cirp_i2c_port_chk
   import cirp_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOeN,
   input wire logic hostMode,
   input wire cirp_cfg_t cfg,
   input wire logic busBusy
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   // Pin checks; sync delay is about three cycles, so allow six
   sdaout_zero_a: assert property (sdaOut == 1'b0)
      else $error("sda output value not low");
   busy_on_start_a: assert property ($past(sclIn) && sclIn && $fell(sdaIn) |-> ##[1:6] busBusy)
      else $error("start not seen as busy");
   free_on_stop_a: assert property ($past(sclIn) && sclIn && $rose(sdaIn) |-> ##[1:6] !busBusy)
      else $error("stop not seen as free");
   idle_release_a: assert property (!busBusy |-> sdaOeN)
      else $error("sda pulled while bus free");
   drive_scl_low_a: assert property ($fell(sdaOeN) |-> !sclIn && !$past(sclIn, 3))
      else $error("sda pulled outside scl low");
   hold_scl_high_a: assert property (sclIn && $past(sclIn, 5) |-> $stable(sdaOeN))
      else $error("sda moved while scl high");
   cfg_reset_a: assert property ($rose(resetn) |-> cfg == 24'h388F95)
      else $error("settings not at defaults");
   cfg_commit_a: assert property ($changed(cfg) && !hostMode && !$past(hostMode)
      |-> busBusy && $rose(sdaOeN))
      else $error("settings changed off a data ack");
endmodule : cirp_i2c_port_chk

bind cirp_i2c_port cirp_i2c_port_chk chk_u (.mclk(mclk), .resetn(resetn), .sclIn(sclIn),
   .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .hostMode(hostMode), .cfg(cfg),
   .busBusy(busBusy));

// ===== cirp_bus_ctrl.sv
module cirp_bus_ctrl
(
   input wire logic mclk,
   input wire logic sdaLine,
   output logic sclOut,
   output logic sdaDrv
);
   timeunit 1ns;
   timeprecision 100ps;

   // Both lines released at power up
   initial
   begin
      sclOut = 1'b1;
      sdaDrv = 1'b1;
   end

   // Four cycles is a quarter of the 80 ns bus period
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick

   // Also a repeated start; returns with SCL low
   task automatic start();
      tick(4);
      sdaDrv = 1'b1;
      tick(4);
      sclOut = 1'b1;
      tick(4);
      sdaDrv = 1'b0;
      tick(6);
      sclOut = 1'b0;
   endtask : start

   task automatic stop();
      tick(4);
      sdaDrv = 1'b0;
      tick(4);
      sclOut = 1'b1;
      tick(4);
      sdaDrv = 1'b1;
      tick(8);
   endtask : stop

   // SDA moves mid low phase, sampled mid high phase
   task automatic sbit(input logic b, output logic r);
      tick(4);
      sdaDrv = b;
      tick(4);
      sclOut = 1'b1;
      tick(4);
      r = sdaLine;
      tick(4);
      sclOut = 1'b0;
   endtask : sbit

   // Sender passes FF to read; ack slot released unless ackIn is 0
   task automatic xbyte(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
      output logic ack);
      for (int i = 7; i >= 0; i--)
         sbit(d[i], q[i]);
      sbit(ackIn, ack);
   endtask : xbyte
endmodule : cirp_bus_ctrl

// ===== tb_charger_i2c_register_port.sv
module tb_charger_i2c_register_port
   import cirp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic mclk = 1'b0;
   logic resetn, hostMode, sclOut, sdaDrv, sdaOut, sdaOeN, busBusy, sdaLine, a;
   logic [7:0] chargeStatus, faultStatus, q;
   logic [7:0] shadow [3];
   cirp_cfg_t cfg;
   int bad_count = 0;
   int compares = 0;
   int seed = 32'h2C87;
   int r;

   always #2.5 mclk = ~mclk;

   // Pull-up wins unless someone pulls low
   assign sdaLine = sdaDrv & (sdaOeN | sdaOut);

   cirp_i2c_port #(.WD_TICK_CYCLES(4), .WD_LIMIT_TICKS(10)) dut_u (.mclk(mclk),
      .resetn(resetn), .sclIn(sclOut), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
      .hostMode(hostMode), .chargeStatus(chargeStatus), .faultStatus(faultStatus),
      .cfg(cfg), .busBusy(busBusy));

   cirp_bus_ctrl ctl_u (.mclk(mclk), .sdaLine(sdaLine), .sclOut(sclOut), .sdaDrv(sdaDrv));

   task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
      compares++;
      if (s !== e)
      begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask : chk

   function automatic logic [7:0] regExp(input int k);
      return (k == 3) ? chargeStatus : (k == 4) ? faultStatus : shadow[k];
   endfunction : regExp

   task automatic sb(input logic [7:0] d, input logic e);
      ctl_u.xbyte(d, 1'b1, q, a);
      chk("ack", a, e);
   endtask : sb

   // Timer bit 6 is a self-clearing kick, so it reads back 0
   task automatic wr(input int k, input logic [7:0] d);
      ctl_u.start();
      chk("busy", busBusy, 1'b1);
      sb({CIRP_TARGET_ADDR, 1'b0}, 1'b0);
      sb(k[7:0], 1'b0);
      sb(d, 1'b0);
      ctl_u.stop();
      chk("free", busBusy, 1'b0);
      if (k < 3)
         shadow[k] = (k == 2) ? (d & 8'hBF) : d;
      chk("cfg", cfg, {shadow[0], shadow[1], shadow[2]});
   endtask : wr

   task automatic rd(input int k);
      ctl_u.start();
      sb({CIRP_TARGET_ADDR, 1'b0}, 1'b0);
      sb(k[7:0], 1'b0);
      ctl_u.start();
      sb({CIRP_TARGET_ADDR, 1'b1}, 1'b0);
      ctl_u.xbyte(8'hFF, 1'b1, q, a);
      ctl_u.stop();
      chk("rdata", q, regExp(k));
   endtask : rd

   task automatic report_and_stop();
      if (bad_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   // Main sequence
   initial
   begin
      resetn = 1'b0;
      hostMode = 1'b0;
      chargeStatus = 8'($random(seed));
      faultStatus = 8'($random(seed));
      shadow = '{8'h38, 8'h8F, 8'h95};
      repeat (4) @(posedge mclk);
      #1;
      resetn = 1'b1;
      ctl_u.tick(4);
      chk("cfgrst", cfg, 24'h388F95);
      for (r = 0; r < 5; r++)
         rd(r);
      repeat (8)
      begin
         r = {$random(seed)} % 5;
         chargeStatus = 8'($random(seed));
         wr(r, 8'($random(seed)));
         rd(r);
      end
      wr(3, 8'hA5);
      rd(3);
      // Undefined register: refused, then port must recover
      for (r = 5; r < 8; r++)
      begin
         ctl_u.start();
         sb(8'h96, 1'b0);
         sb(r[7:0], 1'b1);
         ctl_u.stop();
      end
      rd(0);
      // Other target address is ignored
      ctl_u.start();
      sb({7'h4A, 1'b0}, 1'b1);
      ctl_u.stop();
      // Only the first data byte is taken
      ctl_u.start();
      sb(8'h96, 1'b0);
      sb(8'h01, 1'b0);
      sb(8'h3C, 1'b0);
      sb(8'hC3, 1'b1);
      ctl_u.stop();
      shadow[1] = 8'h3C;
      rd(1);
      // Enable watchdog, then let it lapse with no bus traffic
      wr(2, 8'h95);
      wr(0, 8'h00);
      hostMode = 1'b1;
      ctl_u.tick(300);
      hostMode = 1'b0;
      shadow = '{8'h38, 8'h8F, 8'h95};
      chk("wdog", cfg, {shadow[0], shadow[1], shadow[2]});
      report_and_stop();
   end

   // Runaway guard, well beyond the expected 87 us
   initial
   begin
      #400000;
      bad_count++;
      report_and_stop();
   end
endmodule : tb_charger_i2c_register_port
